//--- vrc_ctrl.sv
`timescale 1ns/1ps
`include "vrc_consts.svh"

// Function
// - Writing bit 7 as one turns the reference on and as zero turns it off unless a hold-on request is active.
// - The ready flag in bit 6 rises only after the reference settle time has passed since enable.
// - Except on the standard-voltage variant, the ready flag reads zero while the reference is disabled or still settling.
// - On the standard-voltage variant the ready flag always reads one.
// - Bit 5 switches the temperature indicator on or off.
// - Bit 4 picks the high range when one and the low range when zero.
// - Bits 3 to 2 set the comparator and DAC buffer gain, code zero turning it off.
// - Bits 1 to 0 set the ADC buffer gain, code zero turning it off.
// - The two buffers take their gains independently of each other.
// - The reference is held on while the internal oscillator is selected, running and not in Sleep.
// - The reference is held on for brown-out mode 11, or modes 10 and 01 with fast start.
// - On the standard-voltage variant the regulator holds the reference on while awake with the regulator power mode input set.
// - All writable bits reset to zero on every reset.
// - A disabled temperature indicator gets no bias, so it draws no current.
module vrc_ctrl #(
    parameter int SETTLE_NS = `VRC_SETTLE_NS,
    parameter bit STD_VOLTAGE = 1'b0
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic [2:0] osc_select_i,
    input wire logic [3:0] internal_freq_select_i,
    input wire logic sleep_i,
    input wire logic [1:0] brownout_enable_mode_i,
    input wire logic brownout_fast_start_i,
    input wire logic regulator_power_mode_i,
    output logic reference_on_o,
    output logic temp_indicator_enable_o,
    output vrc_pkg::vrc_range_t temp_indicator_range_o,
    output logic cmp_buf_on_o,
    output logic [2:0] cmp_gain_sel_o,
    output logic adc_buf_on_o,
    output logic [2:0] adc_gain_sel_o,
    output logic cmp_buf_ready_o,
    output logic adc_buf_ready_o
);
    import vrc_pkg::*;

    localparam int SETTLE_CYC = (SETTLE_NS * `VRC_CLK_MHZ + 999) / 1000;
    localparam int BUF_CYC = `VRC_BUF_SETTLE_US * `VRC_CLK_MHZ;

    initial begin
        if (SETTLE_NS < 1) begin
            $error("SETTLE_NS must be positive");
        end
    end

    // ****************************************************************
    // Pin synchronisers for the system status inputs
    // ****************************************************************
    logic [11:0] sync1_q;
    logic [11:0] sync2_q;
    logic [2:0] osc_s;
    logic [3:0] freq_s;
    logic sleep_s;
    logic [1:0] bor_s;
    logic brownout_fast_start_s;
    logic vreg_s;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= 12'h000;
            sync2_q <= 12'h000;
        end else begin
            sync1_q <= {osc_select_i, internal_freq_select_i, sleep_i, brownout_enable_mode_i,
                        brownout_fast_start_i, regulator_power_mode_i};
            sync2_q <= sync1_q;
        end
    end

    assign {osc_s, freq_s, sleep_s, bor_s, brownout_fast_start_s, vreg_s} = sync2_q;

    // ****************************************************************
    // Wishbone slave: single-cycle ack, unmapped address gives err
    // ****************************************************************
    logic [7:0] ctrl_q;
    logic ack_q;
    logic err_q;
    logic [31:0] dat_q;
    logic req;
    logic hit_ctrl;
    logic hit_sys;
    logic wr_ctrl;
    logic ready_flag;
    logic ref_hold;

    assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    assign hit_ctrl = (wb_adr_i == `VRC_ADDR_CTRL);
    assign hit_sys = (wb_adr_i == `VRC_ADDR_SYSCFG);
    assign wr_ctrl = req && hit_ctrl && wb_we_i && wb_sel_i[0];

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ack_q <= req && (hit_ctrl || hit_sys);
            err_q <= req && !(hit_ctrl || hit_sys);
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;

    // Ready bit is not stored: it is masked out so a write cannot set it
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= `VRC_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= wb_dat_i[7:0] & ~(8'h01 << `VRC_BIT_READY);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dat_q <= 32'h0000_0000;
        end else if (req && !wb_we_i && hit_ctrl) begin
            dat_q <= {24'h000000, ctrl_q[`VRC_BIT_ENABLE], ready_flag, ctrl_q[`VRC_BIT_TEMP_EN:`VRC_ADC_GAIN_LO]};
        end else if (req && !wb_we_i && hit_sys) begin
            dat_q <= {24'h000000, 7'h00, ref_hold};
        end else begin
            dat_q <= 32'h0000_0000;
        end
    end

    assign wb_dat_o = dat_q;

    // ****************************************************************
    // Reference enable and hold-on requests
    // ****************************************************************
    logic osc_need;
    logic bor_need;
    logic ldo_need;
    logic ref_run;

    assign osc_need = (osc_s == `VRC_OSC_SEL_INTERNAL) && (freq_s[3:1] != `VRC_FREQ_OFF_PREFIX)
                      && !sleep_s;
    assign bor_need = (bor_s == `VRC_BOR_ALWAYS)
                      || (((bor_s == `VRC_BOR_NOSLEEP) || (bor_s == `VRC_BOR_SOFT))
                          && brownout_fast_start_s);
    assign ldo_need = STD_VOLTAGE && vreg_s && !sleep_s;
    assign ref_hold = osc_need || bor_need || ldo_need;
    assign ref_run = ctrl_q[`VRC_BIT_ENABLE] || ref_hold;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reference_on_o <= 1'b0;
        end else begin
            reference_on_o <= ref_run;
        end
    end

    // ****************************************************************
    // Ready flag
    // ****************************************************************
    logic settled;

    // Timer follows the software enable; a hold-on alone does not raise the flag
    vrc_settle_timer #(
        .CYCLES(SETTLE_CYC)
    ) u_ref_timer (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(ctrl_q[`VRC_BIT_ENABLE]),
        .done_o(settled)
    );

    assign ready_flag = STD_VOLTAGE ? 1'b1 : settled;

    // ****************************************************************
    // Temperature indicator
    // ****************************************************************
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            temp_indicator_enable_o <= 1'b0;
            temp_indicator_range_o <= VRC_RANGE_LOW;
        end else begin
            temp_indicator_enable_o <= ctrl_q[`VRC_BIT_TEMP_EN];
            temp_indicator_range_o <= vrc_range_t'(ctrl_q[`VRC_BIT_TEMP_RNG]);
        end
    end

    // ****************************************************************
    // Gain buffers
    // ****************************************************************
    vrc_gain_decode u_cmp_gain (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .gain_i(vrc_gain_t'(ctrl_q[`VRC_CMP_GAIN_HI:`VRC_CMP_GAIN_LO])),
        .buf_on_o(cmp_buf_on_o),
        .gain_sel_o(cmp_gain_sel_o)
    );

    vrc_gain_decode u_adc_gain (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .gain_i(vrc_gain_t'(ctrl_q[`VRC_ADC_GAIN_HI:`VRC_ADC_GAIN_LO])),
        .buf_on_o(adc_buf_on_o),
        .gain_sel_o(adc_gain_sel_o)
    );

    // Advisory only: software must still honour the buffer wait itself
    vrc_settle_timer #(
        .CYCLES(BUF_CYC)
    ) u_cmp_timer (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(cmp_buf_on_o),
        .done_o(cmp_buf_ready_o)
    );

    vrc_settle_timer #(
        .CYCLES(BUF_CYC)
    ) u_adc_timer (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(adc_buf_on_o),
        .done_o(adc_buf_ready_o)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Own count of enabled cycles, so ready timing is not judged by the timer it checks
    int en_cyc_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_cyc_q <= 0;
        end else if (!ctrl_q[`VRC_BIT_ENABLE]) begin
            en_cyc_q <= 0;
        end else if (en_cyc_q < SETTLE_CYC) begin
            en_cyc_q <= en_cyc_q + 1;
        end
    end

    // Expected one-hot select, written apart from the decoder under check
    function automatic logic [2:0] sel_for_code(input logic [1:0] code);
        sel_for_code = (code == 2'h0) ? 3'h0 : (3'h1 << (code - 2'h1));
    endfunction : sel_for_code

    chk_ready_needs_enable: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !STD_VOLTAGE && !ctrl_q[`VRC_BIT_ENABLE] |-> !ready_flag)
        else $error("ready set while disabled");

    chk_ready_not_early: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !STD_VOLTAGE && $rose(ctrl_q[`VRC_BIT_ENABLE]) |-> !ready_flag)
        else $error("ready rose at enable");

    chk_ready_timing: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !STD_VOLTAGE |-> ready_flag == (ctrl_q[`VRC_BIT_ENABLE] && (en_cyc_q == SETTLE_CYC)))
        else $error("ready timing wrong");

    chk_std_ready_one: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        STD_VOLTAGE |-> ready_flag)
        else $error("ready low on standard variant");

    chk_enable_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        wr_ctrl |=> ctrl_q[`VRC_BIT_ENABLE] == $past(wb_dat_i[`VRC_BIT_ENABLE]))
        else $error("enable bit not written");

    chk_ref_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !ctrl_q[`VRC_BIT_ENABLE] && !ref_hold |=> !reference_on_o)
        else $error("reference on without request");

    chk_ready_bit_ro: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !ctrl_q[`VRC_BIT_READY])
        else $error("ready bit stored");

    chk_temp_follows: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        wr_ctrl ##1 1'b1 |=> temp_indicator_enable_o == $past(ctrl_q[`VRC_BIT_TEMP_EN]))
        else $error("indicator enable lag");

    chk_temp_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !ctrl_q[`VRC_BIT_TEMP_EN] |=> !temp_indicator_enable_o)
        else $error("indicator biased while disabled");

    chk_range_follows: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        1'b1 |=> temp_indicator_range_o == vrc_range_t'($past(ctrl_q[`VRC_BIT_TEMP_RNG])))
        else $error("indicator range wrong");

    chk_bor_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        bor_s == `VRC_BOR_ALWAYS |=> reference_on_o)
        else $error("brown-out hold missing");

    chk_bor_fast: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ((bor_s == `VRC_BOR_NOSLEEP) || (bor_s == `VRC_BOR_SOFT)) && brownout_fast_start_s |=> reference_on_o)
        else $error("fast start hold missing");

    chk_osc_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        osc_need |=> reference_on_o)
        else $error("oscillator hold missing");

    chk_ldo_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        STD_VOLTAGE && vreg_s && !sleep_s |=> reference_on_o)
        else $error("regulator hold missing");

    chk_gain_indep: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        1'b1 |=> {cmp_buf_on_o, adc_buf_on_o} == {$past(ctrl_q[`VRC_CMP_GAIN_HI:`VRC_CMP_GAIN_LO]) != 2'h0,
        $past(ctrl_q[`VRC_ADC_GAIN_HI:`VRC_ADC_GAIN_LO]) != 2'h0})
        else $error("buffer on state wrong");

    chk_cmp_gain_sel: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        1'b1 |=> cmp_gain_sel_o == sel_for_code($past(ctrl_q[`VRC_CMP_GAIN_HI:`VRC_CMP_GAIN_LO])))
        else $error("comparator gain select wrong");

    chk_adc_gain_sel: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        1'b1 |=> adc_gain_sel_o == sel_for_code($past(ctrl_q[`VRC_ADC_GAIN_HI:`VRC_ADC_GAIN_LO])))
        else $error("adc gain select wrong");

    chk_ack_one: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    chk_ack_given: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        req && (hit_ctrl || hit_sys) |=> wb_ack_o && !wb_err_o)
        else $error("mapped access not acknowledged");

    chk_err_unmapped: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        req && !(hit_ctrl || hit_sys) |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");

    chk_status_ro: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        req && hit_sys && wb_we_i |=> $stable(ctrl_q))
        else $error("status write changed control");

    chk_sel_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        req && hit_ctrl && wb_we_i && !wb_sel_i[0] |=> $stable(ctrl_q))
        else $error("unselected write changed control");

    chk_rdat_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");

    cov_write: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) wr_ctrl);
    cov_ready: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(ready_flag));
    cov_hold: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) ref_hold);
    cov_unmapped: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) wb_err_o);
    cov_buf_ready: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) cmp_buf_ready_o && adc_buf_ready_o);

endmodule : vrc_ctrl

//--- vrc_consts.svh
`ifndef VRC_CONSTS_SVH
`define VRC_CONSTS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define VRC_ADDR_CTRL 4'h0
`define VRC_ADDR_SYSCFG 4'h4
`define VRC_CTRL_RESET 8'h00
`define VRC_SYSCFG_RESET 8'h00

// ****************************************************************
// Control register fields
// ****************************************************************
`define VRC_BIT_ENABLE 7
`define VRC_BIT_READY 6
`define VRC_BIT_TEMP_EN 5
`define VRC_BIT_TEMP_RNG 4
`define VRC_CMP_GAIN_HI 3
`define VRC_CMP_GAIN_LO 2
`define VRC_ADC_GAIN_HI 1
`define VRC_ADC_GAIN_LO 0

// ****************************************************************
// Hold-on request conditions
// ****************************************************************
`define VRC_OSC_SEL_INTERNAL 3'h4
`define VRC_FREQ_OFF_PREFIX 3'h0
`define VRC_BOR_ALWAYS 2'h3
`define VRC_BOR_NOSLEEP 2'h2
`define VRC_BOR_SOFT 2'h1

// ****************************************************************
// Timing
// ****************************************************************
`define VRC_CLK_MHZ 200
`define VRC_SETTLE_NS 20000
`define VRC_BUF_SETTLE_US 30

`endif

//--- vrc_pkg.sv
package vrc_pkg;

    typedef enum logic [1:0] {
        VRC_GAIN_OFF = 2'h0,
        VRC_GAIN_X1 = 2'h1,
        VRC_GAIN_X2 = 2'h2,
        VRC_GAIN_X4 = 2'h3
    } vrc_gain_t;

    typedef enum logic {
        VRC_RANGE_LOW = 1'h0,
        VRC_RANGE_HIGH = 1'h1
    } vrc_range_t;

endpackage : vrc_pkg

//--- vrc_settle_timer.sv
`timescale 1ns/1ps
`include "vrc_consts.svh"

// ****************************************************************
// Restartable settle timer: done rises CYCLES edges after start
// ****************************************************************
module vrc_settle_timer #(
    parameter int CYCLES = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    output logic done_o
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_q;

    initial begin
        if (CYCLES < 1) begin
            $error("CYCLES must be at least one");
        end
    end

    // Drop of run restarts the count, so a re-enable waits in full
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else if (!run_i) begin
            cnt_q <= '0;
        end else if (cnt_q != W'(CYCLES)) begin
            cnt_q <= cnt_q + W'(1);
        end
    end

    assign done_o = run_i && (cnt_q == W'(CYCLES));

endmodule : vrc_settle_timer

//--- vrc_gain_decode.sv
`timescale 1ns/1ps
`include "vrc_consts.svh"

// ****************************************************************
// Buffer gain decode to one-hot analog selects
// ****************************************************************
module vrc_gain_decode (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire vrc_pkg::vrc_gain_t gain_i,
    output logic buf_on_o,
    output logic [2:0] gain_sel_o
);
    import vrc_pkg::*;

    function automatic logic [2:0] gain_onehot(input vrc_gain_t g);
        unique case (g)
            VRC_GAIN_OFF: gain_onehot = 3'h0;
            VRC_GAIN_X1: gain_onehot = 3'h1;
            VRC_GAIN_X2: gain_onehot = 3'h2;
            VRC_GAIN_X4: gain_onehot = 3'h4;
        endcase
    endfunction : gain_onehot

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gain_sel_o <= 3'h0;
            buf_on_o <= 1'b0;
        end else begin
            gain_sel_o <= gain_onehot(gain_i);
            buf_on_o <= (gain_i != VRC_GAIN_OFF);
        end
    end

endmodule : vrc_gain_decode

//--- vrc_analog_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Far-side model: reference level, two gain buffers, sensor drop
// ****************************************************************
module vrc_analog_model #(
    parameter int LEVEL_MV = 1024
) (
    input wire logic ref_on_i,
    input wire logic [2:0] cmp_gain_sel_i,
    input wire logic [2:0] adc_gain_sel_i,
    input wire logic temp_en_i,
    input wire vrc_pkg::vrc_range_t temp_range_i,
    output int cmp_mv_o,
    output int adc_mv_o,
    output int temp_drop_o
);
    import vrc_pkg::*;
    // One-hot select weights equal the gains 1, 2 and 4
    assign cmp_mv_o = ref_on_i ? LEVEL_MV * int'(cmp_gain_sel_i) : 0;
    assign adc_mv_o = ref_on_i ? LEVEL_MV * int'(adc_gain_sel_i) : 0;
    // No bias when disabled, so no junction drop either
    assign temp_drop_o = !temp_en_i ? 0 : (temp_range_i == VRC_RANGE_HIGH) ? 4 : 2;
endmodule : vrc_analog_model

//--- testbench.sv
`timescale 1ns/1ps

module testbench;
    import vrc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, slp = 1'b0, fs = 1'b0, rpm = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'hF, freq = 4'h0;
    logic [31:0] dat = 32'h0, rdat, rd, rdat_s, rd_s;
    logic [2:0] osc = 3'h0, cgs, ags;
    logic [1:0] bor = 2'h0;
    logic ack, err, e, ref_on, ten, cbo, abo, cbr, abr, ref_on_s;
    vrc_range_t rng;
    int error_cnt = 0, compares = 0, cmv, amv, tdrop, v;
    int unsigned seed = 58;

    vrc_ctrl #(.SETTLE_NS(50), .STD_VOLTAGE(1'b0)) i_dut (.ref_clk_i(clk), .rst_n_i(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .osc_select_i(osc), .internal_freq_select_i(freq),
        .sleep_i(slp), .brownout_enable_mode_i(bor), .brownout_fast_start_i(fs),
        .regulator_power_mode_i(rpm), .reference_on_o(ref_on), .temp_indicator_enable_o(ten),
        .temp_indicator_range_o(rng), .cmp_buf_on_o(cbo), .cmp_gain_sel_o(cgs), .adc_buf_on_o(abo),
        .adc_gain_sel_o(ags), .cmp_buf_ready_o(cbr), .adc_buf_ready_o(abr));
    // Standard-voltage variant on the same bus; only its read data and reference output are watched
    vrc_ctrl #(.SETTLE_NS(50), .STD_VOLTAGE(1'b1)) i_dut_std (.ref_clk_i(clk), .rst_n_i(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat_s), .wb_ack_o(), .wb_err_o(), .osc_select_i(osc), .internal_freq_select_i(freq),
        .sleep_i(slp), .brownout_enable_mode_i(bor), .brownout_fast_start_i(fs),
        .regulator_power_mode_i(rpm), .reference_on_o(ref_on_s), .temp_indicator_enable_o(),
        .temp_indicator_range_o(), .cmp_buf_on_o(), .cmp_gain_sel_o(), .adc_buf_on_o(),
        .adc_gain_sel_o(), .cmp_buf_ready_o(), .adc_buf_ready_o());
    vrc_analog_model i_ana (.ref_on_i(ref_on), .cmp_gain_sel_i(cgs), .adc_gain_sel_i(ags),
        .temp_en_i(ten), .temp_range_i(rng), .cmp_mv_o(cmv), .adc_mv_o(amv), .temp_drop_o(tdrop));

    always #2.5 clk = ~clk;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic [2:0] onehot(input int c);
        return (c == 0) ? 3'h0 : 3'h1 << (c - 1);
    endfunction : onehot

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // Classic single cycle; the answer is awaited, never assumed
    task automatic wb(input logic w, input logic [3:0] a, input int d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1 && err !== 1'b1);
        rd = rdat;
        rd_s = rdat_s;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic wrap_up();
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #(50000 * 5);
        error_cnt++;
        wrap_up();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, 4'h0, 0);
        chk("ctrl_reset", 32'h0, rd);
        for (int i = 0; i < 16; i++) begin
            v = (xs() & 8'hF0) | i;
            wb(1'b1, 4'h0, v);
            wb(1'b0, 4'h0, 0);
            chk("ctrl_rdback", v & 8'hBF, rd & 32'hBF);
            repeat (3) @(posedge clk);
            chk("ref_on", v >> 7, ref_on);
            chk("cmp_sel", onehot((v >> 2) & 3), cgs);
            chk("adc_sel", onehot(v & 3), ags);
            chk("bufs_on", {((v >> 2) & 3) != 0, (v & 3) != 0}, {cbo, abo});
            chk("cmp_mv", (v >> 7) * 1024 * onehot((v >> 2) & 3), cmv);
            chk("adc_mv", (v >> 7) * 1024 * onehot(v & 3), amv);
            chk("temp_en", (v >> 5) & 1, ten);
            chk("temp_drop", ((v >> 5) & 1) * (((v >> 4) & 1) ? 4 : 2), tdrop);
        end
        // Drop the enable first so the settle count restarts from zero after the loop
        wb(1'b1, 4'h0, 0);
        wb(1'b1, 4'h0, 32'h80);
        wb(1'b0, 4'h0, 0);
        chk("ready_early", 32'h80, rd);
        chk("std_ready_on", 32'hC0, rd_s);
        repeat (12) @(posedge clk);
        wb(1'b0, 4'h0, 0);
        chk("ready_set", 32'hC0, rd);
        wb(1'b1, 4'h0, 32'h40);
        wb(1'b0, 4'h0, 0);
        chk("ready_clr", 32'h0, rd);
        chk("std_ready_off", 32'h40, rd_s);
        wb(1'b0, 4'h8, 0);
        chk("unmapped_err", 32'h1, e);
        sel <= 4'h0;
        wb(1'b1, 4'h0, 32'hBF);
        sel <= 4'hF;
        wb(1'b0, 4'h0, 0);
        chk("sel_ignored", 32'h0, rd);
        for (int i = 0; i < 32; i++) begin
            osc <= (xs() & 1) ? 3'h4 : 3'(xs());
            freq <= 4'(xs());
            slp <= 1'(xs());
            bor <= 2'(xs());
            fs <= 1'(xs());
            rpm <= 1'(xs());
            repeat (6) @(posedge clk);
            v = (osc == 3'h4 && freq[3:1] != 3'h0 && !slp) || bor == 2'h3 || (bor != 2'h0 && fs);
            chk("hold_ref_on", v, ref_on);
            chk("hold_ref_on_std", v | (rpm & !slp), ref_on_s);
            wb(1'b0, 4'h4, 0);
            chk("hold_status", v, rd);
            chk("hold_status_std", v | (rpm & !slp), rd_s);
        end
        bor <= 2'h0;
        osc <= 3'h0;
        wb(1'b1, 4'h0, 32'h05);
        repeat (5900) @(posedge clk);
        chk("buf_rdy_early", 2'h0, {cbr, abr});
        repeat (200) @(posedge clk);
        chk("buf_rdy", 2'h3, {cbr, abr});
        wb(1'b1, 4'h0, 32'hBF);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, 4'h0, 0);
        chk("ctrl_rereset", 32'h0, rd);
        wrap_up();
    end
endmodule : testbench
